/* common/udcr_pkg.sv */
/*
 * Constants and carrier types for the device command interpreter.
 * Assumes one 125 MHz clock shared by the controller port and the USB engine.
 */
package udcr_pkg;
	// Command codes.
	localparam logic [7:0] CMD_SET_ADDR = 8'hD0;
	localparam logic [7:0] CMD_SET_EP_EN = 8'hD8;
	localparam logic [7:0] CMD_SET_MODE = 8'hF3;
	localparam logic [7:0] CMD_RD_INT = 8'hF4;
	localparam logic [7:0] CMD_RD_FRAME = 8'hF5;
	localparam logic [7:0] CMD_RD_ID = 8'hFD;
	localparam logic [7:0] CMD_DEV_STAT = 8'hFE;
	localparam logic [7:0] CMD_ERR_CODE = 8'hFF;
	localparam logic [7:0] CMD_SEL_CLR_BASE = 8'h40;
	localparam logic [7:0] CMD_SEL_CLR_LAST = 8'h45;
	// Identification value; arbitrary neutral value.
	localparam logic [15:0] CHIP_ID = 16'h5A01;
	// Field positions.
	localparam int FA_EN_BIT = 7;
	localparam int INT_DEV_BIT = 7;
	localparam int ST_SUSP_BIT = 2;
	localparam int ST_SCHG_BIT = 3;
	localparam int ST_BRST_BIT = 4;
	localparam int ERR_OCC_BIT = 4;
	// Reset values.
	localparam logic [7:0] FA_RESET = 8'h00;
	localparam logic [6:0] FA_BUS_RESET = 7'h00;
	localparam logic [7:0] INT_RESET = 8'h00;
	localparam logic [10:0] FRAME_RESET = 11'h000;
	localparam logic [3:0] ERR_RESET = 4'h0;
	// Suspend idle time.
	localparam int CLK_MHZ = 125;
	localparam int SUSP_TIME_MS = 3;
	localparam int SUSP_CYCLES = SUSP_TIME_MS * 1000 * CLK_MHZ;
	// Command or data byte transfer from the controller port.
	typedef struct packed {
		logic wr;
		logic rd;
		logic cmd;
		logic [7:0] data;
	} udcr_acc_t;
	// Events from the serial engine.
	typedef struct packed {
		logic activity;
		logic bus_reset;
		logic addr_status_ok;
		logic sof;
		logic [10:0] sof_frame;
		logic err;
		logic [3:0] err_code;
		logic xfer_start;
		logic [5:0] ep_int;
	} udcr_sie_t;
endpackage

/* src/udcr_cmd_regs.sv */
/*
 * Device command interpreter: decodes command bytes from the embedded
 * controller and serves the data phase of each device-level command.
 * Assumes the serial engine delivers one-cycle event pulses on clk and the
 * controller holds each access for exactly one cycle.
 */
module udcr_cmd_regs #(
	parameter int SUSP_CYCLES = udcr_pkg::SUSP_CYCLES
) (
	input wire logic clk, // 125 MHz clock.
	input wire logic rst, // Synchronous reset, active high.
	input wire udcr_pkg::udcr_acc_t acc, // Controller byte access.
	input wire udcr_pkg::udcr_sie_t sie, // Serial engine events.
	input wire logic sof_crc_err, // Current SOF had a CRC error.
	input wire logic nak_sent, // Device sent a NAK handshake.
	output logic [7:0] rd_data, // Read data byte.
	output logic [6:0] func_addr, // Active function address.
	output logic func_en, // Function enabled.
	output logic ep_enable, // Non-control endpoints enabled.
	output logic nak_report, // Report NAKs mode.
	output logic nak_int, // NAK interrupt pulse.
	output logic suspended, // Suspend state.
	output logic remote_wakeup, // Remote wake-up pulse.
	output logic dev_int // Any interrupt source pending.
);
	typedef enum logic [1:0] {UDCR_IDLE, UDCR_DATA0, UDCR_DATA1, UDCR_DONE} udcr_ph_t;

	udcr_ph_t ph_ff;
	logic [7:0] cmd_ff;
	logic [7:0] pend_addr_ff;
	logic pend_valid_ff;
	logic [6:0] addr_ff;
	logic en_ff;
	logic epen_ff;
	logic mode_ff;
	logic [5:0] epint_ff;
	logic devev_ff;
	logic [10:0] frame_ff;
	logic susp_ff;
	logic schg_ff;
	logic brst_ff;
	logic [3:0] err_ff;
	logic errocc_ff;
	logic [31:0] idle_cnt_ff;
	logic [7:0] rd_data_ff;
	logic wake_ff;
	logic nak_int_ff;
	logic data_rd;
	logic data_wr;
	logic stat_rd;
	logic susp_set;
	logic [7:0] status_byte;
	logic [7:0] nxt_rd;

	// True when the code is one of the select-with-clear endpoint commands.
	function automatic logic is_sel_clr(input logic [7:0] c);
		return c >= udcr_pkg::CMD_SEL_CLR_BASE && c <= udcr_pkg::CMD_SEL_CLR_LAST;
	endfunction

	// Data phase strobes only count after a command byte.
	assign data_rd = acc.rd && !acc.cmd && (ph_ff == UDCR_DATA0 || ph_ff == UDCR_DATA1);
	assign data_wr = acc.wr && !acc.cmd && ph_ff == UDCR_DATA0;
	assign stat_rd = data_rd && cmd_ff == udcr_pkg::CMD_DEV_STAT;
	assign susp_set = !susp_ff && !sie.activity && idle_cnt_ff >= 32'(SUSP_CYCLES);
	assign status_byte = {3'h0, brst_ff, schg_ff, susp_ff, 2'h0};

	// Command phase tracking; a new command byte always restarts it.
	always_ff @(posedge clk) begin
		if (rst) begin
			ph_ff <= UDCR_IDLE;
			cmd_ff <= 8'h00;
		end else if (acc.wr && acc.cmd) begin
			ph_ff <= UDCR_DATA0;
			cmd_ff <= acc.data;
		end else if (data_rd || data_wr) begin
			case (ph_ff)
				UDCR_DATA0: ph_ff <= (cmd_ff == udcr_pkg::CMD_RD_FRAME ||
					cmd_ff == udcr_pkg::CMD_RD_ID) ? UDCR_DATA1 : UDCR_DONE;
				default: ph_ff <= UDCR_DONE;
			endcase
		end
	end

	// Address is held pending until the status stage completes.
	always_ff @(posedge clk) begin
		if (rst) begin
			pend_addr_ff <= udcr_pkg::FA_RESET;
			pend_valid_ff <= 1'b0;
			addr_ff <= udcr_pkg::FA_RESET[6:0];
			en_ff <= 1'b0;
		end else if (sie.bus_reset) begin
			addr_ff <= udcr_pkg::FA_BUS_RESET;
			en_ff <= 1'b1;
			pend_valid_ff <= 1'b0;
		end else if (data_wr && cmd_ff == udcr_pkg::CMD_SET_ADDR) begin
			pend_addr_ff <= acc.data;
			pend_valid_ff <= 1'b1;
		end else if (pend_valid_ff && sie.addr_status_ok) begin
			addr_ff <= pend_addr_ff[6:0];
			en_ff <= pend_addr_ff[udcr_pkg::FA_EN_BIT];
			pend_valid_ff <= 1'b0;
		end
	end

	// Endpoint enable and mode take only bit 0.
	always_ff @(posedge clk) begin
		if (rst) begin
			epen_ff <= 1'b0;
			mode_ff <= 1'b0;
		end else if (data_wr) begin
			if (cmd_ff == udcr_pkg::CMD_SET_EP_EN) epen_ff <= acc.data[0];
			if (cmd_ff == udcr_pkg::CMD_SET_MODE) mode_ff <= acc.data[0];
		end
	end

	// Endpoint flags: a new event wins over a clear in the same cycle.
	always_ff @(posedge clk) begin
		if (rst) begin
			epint_ff <= udcr_pkg::INT_RESET[5:0];
		end else begin
			for (int i = 0; i < 6; i++) begin
				if (sie.ep_int[i] || (mode_ff && nak_sent && i == 0)) begin
					epint_ff[i] <= 1'b1;
				end else if (acc.wr && acc.cmd && is_sel_clr(acc.data) &&
					acc.data[2:0] == 3'(i)) begin
					epint_ff[i] <= 1'b0;
				end
			end
		end
	end

	// Device event flag is set by status changes and cleared on status read.
	always_ff @(posedge clk) begin
		if (rst) begin
			devev_ff <= 1'b0;
		end else if (susp_set || (susp_ff && sie.activity) || sie.bus_reset) begin
			devev_ff <= 1'b1;
		end else if (stat_rd) begin
			devev_ff <= 1'b0;
		end
	end

	// NAK interrupt pulse only in reporting mode.
	always_ff @(posedge clk) begin
		if (rst) nak_int_ff <= 1'b0;
		else nak_int_ff <= mode_ff && nak_sent;
	end

	// Frame number stored raw, even with CRC error; otherwise held.
	always_ff @(posedge clk) begin
		if (rst) frame_ff <= udcr_pkg::FRAME_RESET;
		else if (sie.sof || sof_crc_err) frame_ff <= sie.sof_frame;
	end

	// Idle counter and suspend state.
	always_ff @(posedge clk) begin
		if (rst || sie.activity) idle_cnt_ff <= 32'h0;
		else if (!susp_ff) idle_cnt_ff <= idle_cnt_ff + 32'h1;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			susp_ff <= 1'b0;
			wake_ff <= 1'b0;
		end else begin
			wake_ff <= data_wr && cmd_ff == udcr_pkg::CMD_DEV_STAT && susp_ff &&
				!acc.data[udcr_pkg::ST_SUSP_BIT];
			if (sie.activity) susp_ff <= 1'b0;
			else if (susp_set) susp_ff <= 1'b1;
		end
	end

	// Change and bus reset flags: a set wins over the clear on read.
	always_ff @(posedge clk) begin
		if (rst) begin
			schg_ff <= 1'b0;
			brst_ff <= 1'b0;
		end else begin
			if (susp_set || (susp_ff && sie.activity)) schg_ff <= 1'b1;
			else if (stat_rd) schg_ff <= 1'b0;
			if (sie.bus_reset) brst_ff <= 1'b1;
			else if (stat_rd) brst_ff <= 1'b0;
		end
	end

	// Error capture; a new transfer clears only the occurred flag.
	always_ff @(posedge clk) begin
		if (rst) begin
			err_ff <= udcr_pkg::ERR_RESET;
			errocc_ff <= 1'b0;
		end else if (sie.err) begin
			err_ff <= sie.err_code;
			errocc_ff <= 1'b1;
		end else if (sie.xfer_start) begin
			errocc_ff <= 1'b0;
		end
	end

	// Read data selection by command and byte index.
	always_comb begin
		nxt_rd = 8'h00;
		case (cmd_ff)
			udcr_pkg::CMD_RD_INT: nxt_rd = {devev_ff, 1'b0, epint_ff};
			udcr_pkg::CMD_RD_FRAME: nxt_rd = (ph_ff == UDCR_DATA0) ? frame_ff[7:0] :
				{5'h00, frame_ff[10:8]};
			udcr_pkg::CMD_RD_ID: nxt_rd = (ph_ff == UDCR_DATA0) ? udcr_pkg::CHIP_ID[7:0] :
				udcr_pkg::CHIP_ID[15:8];
			udcr_pkg::CMD_DEV_STAT: nxt_rd = status_byte;
			udcr_pkg::CMD_ERR_CODE: nxt_rd = {3'h0, errocc_ff, err_ff};
			default: nxt_rd = 8'h00;
		endcase
	end

	// Read data is registered; it appears the cycle after the read strobe.
	always_ff @(posedge clk) begin
		if (rst) rd_data_ff <= 8'h00;
		else if (data_rd) rd_data_ff <= nxt_rd;
	end

	assign rd_data = rd_data_ff;
	assign func_addr = addr_ff;
	assign func_en = en_ff;
	assign ep_enable = epen_ff;
	assign nak_report = mode_ff;
	assign nak_int = nak_int_ff;
	assign suspended = susp_ff;
	assign remote_wakeup = wake_ff;
	assign dev_int = devev_ff || (|epint_ff);

	// Checks beside the logic.
	addr_hold_a: assert property (@(posedge clk) disable iff (rst)
		!sie.bus_reset && !(pend_valid_ff && sie.addr_status_ok) |=> $stable(addr_ff))
		else $error("address changed without status stage");
	bus_reset_addr_a: assert property (@(posedge clk) disable iff (rst)
		sie.bus_reset |=> addr_ff == 7'h00 && en_ff)
		else $error("bus reset did not restore default address");
	ep_enable_wr_a: assert property (@(posedge clk) disable iff (rst)
		data_wr && cmd_ff == udcr_pkg::CMD_SET_EP_EN |=> epen_ff == $past(acc.data[0]))
		else $error("endpoint enable not written");
	devev_clear_a: assert property (@(posedge clk) disable iff (rst)
		stat_rd && !sie.bus_reset && !susp_set && !sie.activity |=> !devev_ff)
		else $error("device event not cleared by status read");
	frame_hold_a: assert property (@(posedge clk) disable iff (rst)
		!sie.sof && !sof_crc_err |=> $stable(frame_ff))
		else $error("frame number changed without start of frame");
	id_order_a: assert property (@(posedge clk) disable iff (rst)
		data_rd && cmd_ff == udcr_pkg::CMD_RD_ID && ph_ff == UDCR_DATA0
		|=> rd_data == udcr_pkg::CHIP_ID[7:0])
		else $error("identifier low byte not first");
	status_rsvd_a: assert property (@(posedge clk) disable iff (rst)
		stat_rd |=> rd_data[1:0] == 2'h0 && rd_data[7:5] == 3'h0)
		else $error("reserved status bits not zero");
	susp_event_a: assert property (@(posedge clk) disable iff (rst)
		susp_set |=> devev_ff && schg_ff && susp_ff)
		else $error("suspend entry did not raise event");
	wake_a: assert property (@(posedge clk) disable iff (rst)
		remote_wakeup |-> $past(susp_ff))
		else $error("wake-up without suspend");
	intr_rsvd_a: assert property (@(posedge clk) disable iff (rst)
		data_rd && cmd_ff == udcr_pkg::CMD_RD_INT
		|=> !rd_data[6] && rd_data[7] == $past(devev_ff)
		&& rd_data[5:0] == $past(epint_ff))
		else $error("interrupt source byte wrong");
	ep_flag_hold_a: assert property (@(posedge clk) disable iff (rst)
		epint_ff[0] && !(acc.wr && acc.cmd && acc.data == udcr_pkg::CMD_SEL_CLR_BASE)
		|=> epint_ff[0])
		else $error("endpoint flag cleared without select command");
	ep_flag_clr_a: assert property (@(posedge clk) disable iff (rst)
		acc.wr && acc.cmd && acc.data == udcr_pkg::CMD_SEL_CLR_BASE && !sie.ep_int[0]
		&& !(mode_ff && nak_sent) |=> !epint_ff[0])
		else $error("endpoint flag not cleared by select command");
	frame_high_a: assert property (@(posedge clk) disable iff (rst)
		data_rd && cmd_ff == udcr_pkg::CMD_RD_FRAME && ph_ff == UDCR_DATA1
		|=> rd_data == {5'h00, $past(frame_ff[10:8])})
		else $error("frame number high byte wrong");
	sof_crc_a: assert property (@(posedge clk) disable iff (rst)
		sof_crc_err |=> frame_ff == $past(sie.sof_frame))
		else $error("corrupted frame number not stored");
	err_clear_a: assert property (@(posedge clk) disable iff (rst)
		sie.xfer_start && !sie.err |=> !errocc_ff)
		else $error("error flag not cleared by new transfer");
	data_len_a: assert property (@(posedge clk) disable iff (rst)
		acc.rd && !acc.cmd && ph_ff == UDCR_DONE |=> $stable(rd_data))
		else $error("read beyond data phase changed read data");
	cover_addr_c: cover property (@(posedge clk) disable iff (rst)
		pend_valid_ff && sie.addr_status_ok);
	cover_frame_c: cover property (@(posedge clk) disable iff (rst)
		data_rd && cmd_ff == udcr_pkg::CMD_RD_FRAME && ph_ff == UDCR_DATA1);
	cover_susp_c: cover property (@(posedge clk) disable iff (rst) susp_set);
	cover_wake_c: cover property (@(posedge clk) disable iff (rst)
		remote_wakeup);
	cover_clr_c: cover property (@(posedge clk) disable iff (rst)
		sie.xfer_start && errocc_ff);
endmodule

/* testbench/udcr_sie_model.sv */
/*
 * Behavioural serial engine that stands beside the command interpreter.
 * Assumes the bench calls pulse() for events and drives keep_alive by NBA.
 */
module udcr_sie_model (
	input wire logic clk, // Shared 125 MHz clock.
	input wire logic rst, // Synchronous reset, active high.
	output udcr_pkg::udcr_sie_t sie, // Event pulses towards the interpreter.
	output logic sof_crc_err, // Frame marker arrived with a bad checksum.
	output logic nak_sent // A NAK handshake went out.
);
	timeunit 1ns;
	timeprecision 1ps;
	logic keep_alive = 1'b1;
	logic [2:0] tick_cnt;
	udcr_pkg::udcr_sie_t ev_q;

	// Outputs start quiet so the interpreter sees no stray event.
	initial begin
		ev_q = '0;
		sof_crc_err = 1'b0;
		nak_sent = 1'b0;
	end

	// Upstream traffic every eighth cycle keeps the device awake until told to stop.
	always @(posedge clk) begin
		tick_cnt <= rst ? 3'h0 : tick_cnt + 3'h1;
	end

	// Activity is merged here so explicit events and keep-alive never fight.
	always_comb begin
		sie = ev_q;
		sie.activity = ev_q.activity | (keep_alive && tick_cnt == 3'h7);
	end

	// One-cycle event; afterwards the data fields show inverted values, not stale ones.
	task automatic pulse(input udcr_pkg::udcr_sie_t e, input logic crc, input logic nak);
		@(posedge clk);
		ev_q <= e;
		sof_crc_err <= crc;
		nak_sent <= nak;
		@(posedge clk);
		ev_q <= '{sof_frame: ~e.sof_frame, err_code: ~e.err_code, default: '0};
		sof_crc_err <= 1'b0;
		nak_sent <= 1'b0;
	endtask
endmodule

/* testbench/testbench.sv */
/*
 * Self-checking bench for the device command interpreter.
 * Assumes the design package is compiled first and suspend idle is shortened.
 */
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk;
	logic rst;
	udcr_pkg::udcr_acc_t acc;
	udcr_pkg::udcr_sie_t sie;
	logic sof_crc_err;
	logic nak_sent;
	logic [7:0] rd_data;
	logic [6:0] func_addr;
	logic func_en, ep_enable, nak_report, nak_int, suspended, remote_wakeup, dev_int;
	int n_mismatch = 0;
	int samples_checked = 0;
	int nak_cnt = 0;
	int wake_cnt = 0;
	int k;

	udcr_cmd_regs #(.SUSP_CYCLES(20)) dut_u (.clk(clk), .rst(rst), .acc(acc), .sie(sie),
		.sof_crc_err(sof_crc_err), .nak_sent(nak_sent), .rd_data(rd_data),
		.func_addr(func_addr), .func_en(func_en), .ep_enable(ep_enable),
		.nak_report(nak_report), .nak_int(nak_int), .suspended(suspended),
		.remote_wakeup(remote_wakeup), .dev_int(dev_int));
	udcr_sie_model sie_u (.clk(clk), .rst(rst), .sie(sie), .sof_crc_err(sof_crc_err),
		.nak_sent(nak_sent));

	// Free-running clock, 8 ns period.
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Pulse outputs are counted so a stretched or missing pulse shows as a wrong count.
	always @(posedge clk) begin
		if (!rst) begin
			if (nak_int === 1'b1) nak_cnt++;
			if (remote_wakeup === 1'b1) wake_cnt++;
		end
	end

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic access(input logic wr, input logic rd, input logic cmd, input logic [7:0] d);
		@(posedge clk);
		acc <= '{wr: wr, rd: rd, cmd: cmd, data: d};
		@(posedge clk);
		acc <= '0;
	endtask

	task automatic rd_byte(input logic [7:0] exp);
		access(1'b0, 1'b1, 1'b0, 8'h00);
		#1;
		check(rd_data, exp);
	endtask

	task automatic reg_rd(input logic [7:0] c, input logic [7:0] exp);
		access(1'b1, 1'b0, 1'b1, c);
		rd_byte(exp);
	endtask

	task automatic wr_reg(input logic [7:0] c, input logic [7:0] d);
		access(1'b1, 1'b0, 1'b1, c);
		access(1'b1, 1'b0, 1'b0, d);
		@(posedge clk);
		#1;
	endtask

	task automatic final_report();
		$display("Checks made: %0d, mismatches: %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// A hang is cut short far beyond the few hundred cycles the tests need.
	initial begin
		#(20000 * 8);
		n_mismatch++;
		final_report();
	end

	initial begin
		rst = 1'b1;
		acc = '0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		check({func_en, func_addr}, 8'h00);
		check({ep_enable, nak_report}, 2'b00);
		reg_rd(udcr_pkg::CMD_RD_INT, 8'h00);
		reg_rd(udcr_pkg::CMD_ERR_CODE, 8'h00);
		reg_rd(udcr_pkg::CMD_DEV_STAT, 8'h00);
		reg_rd(udcr_pkg::CMD_RD_ID, udcr_pkg::CHIP_ID[7:0]);
		rd_byte(udcr_pkg::CHIP_ID[15:8]);
		rd_byte(udcr_pkg::CHIP_ID[15:8]);
		// The address must wait for a good status stage.
		wr_reg(udcr_pkg::CMD_SET_ADDR, 8'hA5);
		check({func_en, func_addr}, 8'h00);
		sie_u.pulse('{addr_status_ok: 1'b1, default: '0}, 1'b0, 1'b0);
		@(posedge clk);
		#1;
		check({func_en, func_addr}, 8'hA5);
		sie_u.pulse('{bus_reset: 1'b1, default: '0}, 1'b0, 1'b0);
		@(posedge clk);
		#1;
		check({func_en, func_addr, dev_int}, 9'h101);
		reg_rd(udcr_pkg::CMD_RD_INT, 8'h80);
		reg_rd(udcr_pkg::CMD_DEV_STAT, 8'h10);
		reg_rd(udcr_pkg::CMD_RD_INT, 8'h00);
		reg_rd(udcr_pkg::CMD_DEV_STAT, 8'h00);
		wr_reg(udcr_pkg::CMD_SET_EP_EN, 8'hFF);
		check(ep_enable, 1'b1);
		wr_reg(udcr_pkg::CMD_SET_EP_EN, 8'hFE);
		check(ep_enable, 1'b0);
		// NAKs are reported only in mode one.
		wr_reg(udcr_pkg::CMD_SET_MODE, 8'h01);
		check(nak_report, 1'b1);
		k = nak_cnt;
		sie_u.pulse('{default: '0}, 1'b0, 1'b1);
		repeat (2) @(posedge clk);
		#1;
		check(16'(nak_cnt - k), 16'h0001);
		reg_rd(udcr_pkg::CMD_RD_INT, 8'h01);
		access(1'b1, 1'b0, 1'b1, udcr_pkg::CMD_SEL_CLR_BASE);
		reg_rd(udcr_pkg::CMD_RD_INT, 8'h00);
		wr_reg(udcr_pkg::CMD_SET_MODE, 8'h00);
		sie_u.pulse('{default: '0}, 1'b0, 1'b1);
		reg_rd(udcr_pkg::CMD_RD_INT, 8'h00);
		check(16'(nak_cnt - k), 16'h0001);
		// Each select-with-clear drops only its own endpoint flag.
		sie_u.pulse('{ep_int: 6'h3F, default: '0}, 1'b0, 1'b0);
		reg_rd(udcr_pkg::CMD_RD_INT, 8'h3F);
		for (int n = 0; n < 6; n++) begin
			access(1'b1, 1'b0, 1'b1, udcr_pkg::CMD_SEL_CLR_BASE + 8'(n));
			reg_rd(udcr_pkg::CMD_RD_INT, 8'h3F & (8'hFF << (n + 1)));
		end
		sie_u.pulse('{sof: 1'b1, sof_frame: 11'h5A3, default: '0}, 1'b0, 1'b0);
		reg_rd(udcr_pkg::CMD_RD_FRAME, 8'hA3);
		rd_byte(8'h05);
		reg_rd(udcr_pkg::CMD_RD_FRAME, 8'hA3);
		sie_u.pulse('{sof: 1'b1, sof_frame: 11'h7FF, default: '0}, 1'b1, 1'b0);
		repeat (40) @(posedge clk);
		reg_rd(udcr_pkg::CMD_RD_FRAME, 8'hFF);
		rd_byte(8'h07);
		sie_u.pulse('{err: 1'b1, err_code: 4'hB, default: '0}, 1'b0, 1'b0);
		reg_rd(udcr_pkg::CMD_ERR_CODE, 8'h1B);
		sie_u.pulse('{xfer_start: 1'b1, default: '0}, 1'b0, 1'b0);
		reg_rd(udcr_pkg::CMD_ERR_CODE, 8'h0B);
		// Silence upstream until the device suspends, then wake it.
		@(posedge clk);
		sie_u.keep_alive <= 1'b0;
		repeat (40) @(posedge clk);
		#1;
		check({suspended, dev_int}, 2'b11);
		reg_rd(udcr_pkg::CMD_DEV_STAT, 8'h0C);
		reg_rd(udcr_pkg::CMD_RD_INT, 8'h00);
		k = wake_cnt;
		wr_reg(udcr_pkg::CMD_DEV_STAT, 8'h04);
		check(16'(wake_cnt - k), 16'h0000);
		wr_reg(udcr_pkg::CMD_DEV_STAT, 8'h00);
		@(posedge clk);
		#1;
		check(16'(wake_cnt - k), 16'h0001);
		sie_u.keep_alive <= 1'b1;
		repeat (20) @(posedge clk);
		#1;
		check(suspended, 1'b0);
		reg_rd(udcr_pkg::CMD_DEV_STAT, 8'h08);
		final_report();
	end
endmodule
